// ==== design/arwd_top.sv ====
// Result formatter, SAR clock divider, conversion sequencer and window detector.
// Assumes the converter core holds code_in and diff_in stable on this clock and
// that trigger logic on the same clock pulses conv_trigger_in for non-software modes.
// Function
// - Right-justified: top four code bits in high byte 3..0, low eight bits in the low byte.
// - Right-justified high byte bits 7..4 copy bit 3 if differential, else read zero.
// - Left-justified: top eight bits in the high byte, low four in low byte 7..4, zeros below.
// - Single-ended codes are unsigned 12-bit, differential codes are 12-bit two's complement.
// - Every new result is compared in hardware with both limit words; a match sets a flag.
// - Each limit word is assembled from separately writable high and low byte registers.
// - The flag fires inside or outside the window depending on how the two limits are ordered.
// - Software can read the window flag for polling.
// - A conversion lasts exactly sixteen SAR clock periods until result lands, busy drops.
// - Busy is high during conversion and its falling edge sets the sticky done flag.
// - The window flag stays set after a match until software writes it to zero.
// - The SAR clock is the system clock divided by one plus the five-bit divider field.
// - Justify select zero means right-justified, one means left-justified.
`timescale 1ns/1ps
`default_nettype none
module arwd_top (
  input wire logic ref_clk_in,
  input wire logic arst_n_in,
  input wire logic [7:0] sfr_addr_in,
  input wire logic sfr_wr_in,
  input wire logic [7:0] sfr_wdata_in,
  output logic [7:0] sfr_rdata_out,
  input wire logic conv_trigger_in,
  input wire logic [11:0] code_in,
  input wire logic diff_in,
  output logic sar_clk_out,
  output logic enable_out,
  output logic busy_out,
  output logic done_flag_out,
  output logic window_flag_out
);
  logic [7:0] ctl_q, cfg_q, res_lo_q, res_hi_q, gt_hi_q, gt_lo_q, lt_hi_q, lt_lo_q, rd_q;
  logic busy_q, done_q, win_q, sar_clk_q, diff_q;
  logic [4:0] div_lat_q, pre_q;
  logic [3:0] sar_cnt_q;
  logic [9:0] len_q;
  logic [15:0] fmt_word;
  logic start, tick, finish, hit;

  // Justify a raw code into the 16-bit result word.
  function automatic logic [15:0] fmt(input logic [11:0] c, input logic d, input logic lj);
    if (lj) begin
      fmt = {c, 4'h0};
    end else begin
      fmt = {{4{d & c[11]}}, c};
    end
  endfunction

  // Window test; flipping the top bit turns an unsigned compare into a signed one.
  function automatic logic win_hit(input logic [15:0] r, input logic [15:0] gt,
                                   input logic [15:0] lt, input logic sgn);
    logic [15:0] rx, gx, lx;
    rx = {r[15] ^ sgn, r[14:0]};
    gx = {gt[15] ^ sgn, gt[14:0]};
    lx = {lt[15] ^ sgn, lt[14:0]};
    if (lx > gx) begin
      win_hit = (rx > gx) && (rx < lx);
    end else begin
      win_hit = (rx < lx) || (rx > gx);
    end
  endfunction

  wire ctl_wr = sfr_wr_in && (sfr_addr_in == arwd_pkg::ADDR_CONTROL);
  wire cfg_wr = sfr_wr_in && (sfr_addr_in == arwd_pkg::ADDR_CONFIG);

  // Start, SAR tick and end of conversion decode.
  always_comb begin
    start = ctl_q[arwd_pkg::CTL_ENABLE] && !busy_q &&
            ((ctl_wr && sfr_wdata_in[arwd_pkg::CTL_BUSY] &&
              ctl_q[arwd_pkg::CTL_MODE_HI:arwd_pkg::CTL_MODE_LO] == arwd_pkg::MODE_SOFTWARE) ||
             (conv_trigger_in &&
              ctl_q[arwd_pkg::CTL_MODE_HI:arwd_pkg::CTL_MODE_LO] != arwd_pkg::MODE_SOFTWARE));
    tick = busy_q && (pre_q == div_lat_q);
    finish = tick && (sar_cnt_q == arwd_pkg::SAR_LAST_PERIOD);
    fmt_word = fmt(code_in, diff_in, ctl_q[arwd_pkg::CTL_JUSTIFY]);
    hit = win_hit(fmt_word, {gt_hi_q, gt_lo_q}, {lt_hi_q, lt_lo_q}, diff_in);
  end

  // Software-owned control fields; hardware owns busy and both flags.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      ctl_q <= arwd_pkg::RST_CONTROL;
    end else if (ctl_wr) begin
      ctl_q <= sfr_wdata_in;
    end
  end

  // Configuration register holding the divider and gain fields.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      cfg_q <= arwd_pkg::RST_CONFIG;
    end else if (cfg_wr) begin
      cfg_q <= sfr_wdata_in;
    end
  end

  // Limit bytes, each writable on its own address.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      gt_hi_q <= arwd_pkg::RST_GT_HI;
      gt_lo_q <= arwd_pkg::RST_GT_LO;
      lt_hi_q <= arwd_pkg::RST_LT_HI;
      lt_lo_q <= arwd_pkg::RST_LT_LO;
    end else if (sfr_wr_in) begin
      if (sfr_addr_in == arwd_pkg::ADDR_GT_HI) gt_hi_q <= sfr_wdata_in;
      if (sfr_addr_in == arwd_pkg::ADDR_GT_LO) gt_lo_q <= sfr_wdata_in;
      if (sfr_addr_in == arwd_pkg::ADDR_LT_HI) lt_hi_q <= sfr_wdata_in;
      if (sfr_addr_in == arwd_pkg::ADDR_LT_LO) lt_lo_q <= sfr_wdata_in;
    end
  end

  // Conversion sequencer; the divider is latched at start so a mid-conversion
  // write cannot stretch or shorten the running conversion.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      busy_q <= 1'b0;
      div_lat_q <= 5'h00;
      pre_q <= 5'h00;
      sar_cnt_q <= 4'h0;
      sar_clk_q <= 1'b0;
    end else begin
      if (start) begin
        busy_q <= 1'b1;
        div_lat_q <= cfg_q[arwd_pkg::CFG_DIV_HI:arwd_pkg::CFG_DIV_LO];
        pre_q <= 5'h00;
        sar_cnt_q <= 4'h0;
      end else if (busy_q) begin
        pre_q <= tick ? 5'h00 : pre_q + 5'h01;
        if (tick) sar_cnt_q <= sar_cnt_q + 4'h1;
        if (finish) busy_q <= 1'b0;
      end
      sar_clk_q <= busy_q && !start && (pre_q <= {1'b0, div_lat_q[4:1]});
    end
  end

  // Result bytes are written in the cycle busy falls.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      res_lo_q <= arwd_pkg::RST_RES;
      res_hi_q <= arwd_pkg::RST_RES;
      diff_q <= 1'b0;
    end else if (finish) begin
      {res_hi_q, res_lo_q} <= fmt_word;
      diff_q <= diff_in;
    end
  end

  // Sticky flags: a hardware set beats a software clear in the same cycle.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      done_q <= 1'b0;
      win_q <= 1'b0;
    end else begin
      if (finish) done_q <= 1'b1;
      else if (ctl_wr) done_q <= sfr_wdata_in[arwd_pkg::CTL_DONE];
      if (finish && hit) win_q <= 1'b1;
      else if (ctl_wr) win_q <= sfr_wdata_in[arwd_pkg::CTL_WINDOW];
    end
  end

  // Registered read port; unmapped addresses read as zero.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rd_q <= 8'h00;
    end else begin
      case (sfr_addr_in)
        arwd_pkg::ADDR_CONTROL: rd_q <= {ctl_q[7:6], done_q, busy_q, ctl_q[3:2], win_q,
                                         ctl_q[0]};
        arwd_pkg::ADDR_CONFIG: rd_q <= cfg_q;
        arwd_pkg::ADDR_RES_LO: rd_q <= res_lo_q;
        arwd_pkg::ADDR_RES_HI: rd_q <= res_hi_q;
        arwd_pkg::ADDR_GT_HI: rd_q <= gt_hi_q;
        arwd_pkg::ADDR_GT_LO: rd_q <= gt_lo_q;
        arwd_pkg::ADDR_LT_HI: rd_q <= lt_hi_q;
        arwd_pkg::ADDR_LT_LO: rd_q <= lt_lo_q;
        default: rd_q <= 8'h00;
      endcase
    end
  end

  // Cycle counter of the running conversion, read only by the checks.
  always_ff @(posedge ref_clk_in or negedge arst_n_in) begin
    if (!arst_n_in) len_q <= 10'h000;
    else if (start) len_q <= 10'h000;
    else if (busy_q) len_q <= len_q + 10'h001;
  end

  assign sfr_rdata_out = rd_q;
  assign sar_clk_out = sar_clk_q;
  assign enable_out = ctl_q[arwd_pkg::CTL_ENABLE];
  assign busy_out = busy_q;
  assign done_flag_out = done_q;
  assign window_flag_out = win_q;

  chk_conv_length: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    $fell(busy_q) |-> len_q == 10'(arwd_pkg::SAR_PERIODS * (int'(div_lat_q) + 1)))
    else $error("conversion length wrong");
  chk_done_on_fall: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    $fell(busy_q) |-> done_q) else $error("done flag not set at busy fall");
  chk_start_busy: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    start |=> busy_q [*2]) else $error("busy did not rise on start");
  chk_right_format: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    $fell(busy_q) && !$past(ctl_q[0]) |-> {res_hi_q[3:0], res_lo_q} == $past(code_in) &&
      res_hi_q[7:4] == (diff_q ? {4{res_hi_q[3]}} : 4'h0)) else $error("right format wrong");
  chk_left_format: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    $fell(busy_q) && $past(ctl_q[0]) |-> {res_hi_q, res_lo_q} == {$past(code_in), 4'h0})
    else $error("left format wrong");
  chk_window_sticky: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    win_q && !ctl_wr |=> win_q) else $error("window flag dropped");
  chk_window_set: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    finish && hit |=> win_q && done_q) else $error("window match lost");
  chk_flag_read: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)
    sfr_addr_in == arwd_pkg::ADDR_CONTROL |=> sfr_rdata_out[1] == $past(win_q) &&
      sfr_rdata_out[4] == $past(busy_q)) else $error("control read wrong");
endmodule // arwd_top
`default_nettype wire

// ==== design/arwd_pkg.sv ====
// Constants for the converter result formatter and window detector.
// Assumes a processor-side register port with byte-wide addresses and data.
package arwd_pkg;
  // Register addresses on the special-function register port.
  localparam logic [7:0] ADDR_CONFIG = 8'hbc;
  localparam logic [7:0] ADDR_RES_LO = 8'hbe;
  localparam logic [7:0] ADDR_RES_HI = 8'hbf;
  localparam logic [7:0] ADDR_CONTROL = 8'he8;
  localparam logic [7:0] ADDR_LT_LO = 8'hc4;
  localparam logic [7:0] ADDR_LT_HI = 8'hc5;
  localparam logic [7:0] ADDR_GT_LO = 8'hc6;
  localparam logic [7:0] ADDR_GT_HI = 8'hc7;
  // Reset values.
  localparam logic [7:0] RST_CONFIG = 8'hf8;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_RES = 8'h00;
  localparam logic [7:0] RST_GT_HI = 8'hff;
  localparam logic [7:0] RST_GT_LO = 8'hff;
  localparam logic [7:0] RST_LT_HI = 8'h00;
  localparam logic [7:0] RST_LT_LO = 8'h00;
  // Control register bit positions.
  localparam int CTL_ENABLE = 7;
  localparam int CTL_TRACK = 6;
  localparam int CTL_DONE = 5;
  localparam int CTL_BUSY = 4;
  localparam int CTL_MODE_HI = 3;
  localparam int CTL_MODE_LO = 2;
  localparam int CTL_WINDOW = 1;
  localparam int CTL_JUSTIFY = 0;
  // Configuration register fields.
  localparam int CFG_DIV_HI = 7;
  localparam int CFG_DIV_LO = 3;
  localparam int CFG_GAIN_HI = 2;
  // Start mode that takes its start from the busy bit write.
  localparam logic [1:0] MODE_SOFTWARE = 2'h0;
  // SAR clock periods per conversion.
  localparam logic [3:0] SAR_LAST_PERIOD = 4'hf;
  localparam int SAR_PERIODS = 16;
endpackage

// ==== sim/arwd_cpu_model.sv ====
// Processor-side model that writes and reads the special-function registers.
// Assumes the block samples the register port on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module arwd_cpu_model (
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  output logic [7:0] addr_out,
  output logic wr_out,
  output logic [7:0] wdata_out
);
  // Port is quiet until the first request.
  initial begin
    addr_out = 8'h00;
    wr_out = 1'b0;
    wdata_out = 8'h00;
  end
  // One write, held across exactly one rising edge.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    wdata_out = d;
    wr_out = 1'b1;
    @(negedge clk_in);
    wr_out = 1'b0;
    wdata_out = ~d; // Stale data is inverted so a late sample cannot match.
  endtask
  // The answer is registered, so it is taken one edge after the address.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_in);
    addr_out = a;
    @(negedge clk_in);
    d = rdata_in;
  endtask
endmodule // arwd_cpu_model
`default_nettype wire

// ==== sim/testbench.sv ====
// Self-checking bench for the result formatter and window detector.
// Assumes the processor model drives the register port at falling edges.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic clk = 1'b0;
  logic arst_n, trig, df, lj, trg, w, ew;
  logic [11:0] code;
  logic [7:0] addr, wdata, rdata, b;
  logic wr, en, busy, done, win, sclk;
  logic sclk_q = 1'b0;
  logic [15:0] r, gt, lt;
  logic [4:0] div;
  int error_cnt = 0, num_checks = 0, bcnt = 0, s, L, sck = 0, sc;
  logic [7:0] ra [9] = '{arwd_pkg::ADDR_CONFIG, arwd_pkg::ADDR_CONTROL, arwd_pkg::ADDR_RES_LO,
    arwd_pkg::ADDR_RES_HI, arwd_pkg::ADDR_GT_HI, arwd_pkg::ADDR_GT_LO, arwd_pkg::ADDR_LT_HI,
    arwd_pkg::ADDR_LT_LO, 8'h01};
  logic [7:0] rv [9] = '{arwd_pkg::RST_CONFIG, arwd_pkg::RST_CONTROL, arwd_pkg::RST_RES,
    arwd_pkg::RST_RES, arwd_pkg::RST_GT_HI, arwd_pkg::RST_GT_LO, arwd_pkg::RST_LT_HI,
    arwd_pkg::RST_LT_LO, 8'h00};
  arwd_top arwd_top_i (.ref_clk_in(clk), .arst_n_in(arst_n), .sfr_addr_in(addr),
    .sfr_wr_in(wr), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata), .conv_trigger_in(trig),
    .code_in(code), .diff_in(df), .sar_clk_out(sclk), .enable_out(en), .busy_out(busy),
    .done_flag_out(done), .window_flag_out(win));
  arwd_cpu_model arwd_cpu_model_i (.clk_in(clk), .rdata_in(rdata), .addr_out(addr),
    .wr_out(wr), .wdata_out(wdata));
  // Clock, and a count of cycles spent busy sampled before each edge lands.
  always #2.5 clk = ~clk;
  always @(posedge clk) if (busy === 1'b1) bcnt++;
  // Rising edges of the SAR clock pin, counted one edge after they appear.
  always @(posedge clk) begin
    if (sclk === 1'b1 && sclk_q !== 1'b1) sck++;
    sclk_q <= sclk;
  end
  // Expected stored word from code, input kind and justify select.
  function automatic logic [15:0] just(logic [11:0] c, logic d, logic l);
    if (l) return {c, 4'h0};
    return d ? {{4{c[11]}}, c} : {4'h0, c};
  endfunction
  // Window test on the stored word; signed only for differential input.
  function automatic logic hit(logic [15:0] x, logic [15:0] g, logic [15:0] t, logic d);
    int v, gi, ti;
    v = d ? int'($signed(x)) : int'(x);
    gi = d ? int'($signed(g)) : int'(g);
    ti = d ? int'($signed(t)) : int'(t);
    if (ti > gi) return v > gi && v < ti;
    return v < ti || v > gi;
  endfunction
  task automatic chk(string n, logic [15:0] sn, logic [15:0] ex);
    num_checks++;
    if (sn !== ex) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", n, ex, sn);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // A hang far beyond the expected few thousand cycles ends the run.
  initial begin
    #200000;
    error_cnt++;
    close_out();
  end
  // Reset values first, then random conversions in both start modes.
  initial begin
    arst_n = 1'b0; trig = 1'b0; df = 1'b0; code = 12'h000; ew = 1'b0;
    repeat (12) @(posedge clk);
    @(negedge clk) arst_n = 1'b1;
    void'($urandom(32'h3910));
    arwd_cpu_model_i.wr(8'h01, 8'h5a);
    foreach (ra[i]) begin
      arwd_cpu_model_i.rd(ra[i], b);
      chk("reset_value", b, rv[i]);
    end
    $display("test reset done");
    for (int k = 0; k < 24; k++) begin
      // No five-bit divider keeps the SAR clock legal at this system clock, so the bench
      // runs short divisors for pace and the longest one to reach the top of the field.
      div = k[3] ? 5'h1f : 5'($urandom_range(3));
      code = 12'($urandom); df = 1'($urandom);
      lj = 1'($urandom); trg = 1'($urandom);
      r = just(code, df, lj);
      gt = k[1] ? 16'($urandom) : r + 16'($urandom_range(4)) - 16'h2;
      lt = k[2] ? 16'($urandom) : r + 16'($urandom_range(4)) - 16'h2;
      arwd_cpu_model_i.wr(arwd_pkg::ADDR_CONFIG, {div, 3'h0});
      arwd_cpu_model_i.wr(arwd_pkg::ADDR_GT_HI, gt[15:8]);
      arwd_cpu_model_i.wr(arwd_pkg::ADDR_GT_LO, gt[7:0]);
      arwd_cpu_model_i.wr(arwd_pkg::ADDR_LT_HI, lt[15:8]);
      arwd_cpu_model_i.wr(arwd_pkg::ADDR_LT_LO, lt[7:0]);
      w = k[0] & ew;
      s = bcnt;
      sc = sck;
      // Enable and mode land first, since a busy bit write is judged by the stored mode.
      arwd_cpu_model_i.wr(arwd_pkg::ADDR_CONTROL, 8'h80 | {5'h0, trg, w, lj});
      arwd_cpu_model_i.wr(arwd_pkg::ADDR_CONTROL, 8'h90 | {5'h0, trg, w, lj});
      if (trg) begin
        chk("busy_refused", busy, 1'b0);
        trig = 1'b1;
        @(negedge clk) trig = 1'b0;
      end
      while (bcnt == s || busy !== 1'b0) @(negedge clk);
      L = 16 * (div + 1);
      chk("busy_len", bcnt - s >= L && bcnt - s <= L + 1, 1'b1);
      // At divider zero the SAR clock equals the system clock, so the pin just stands high.
      chk("sar_edges", 16'(sck - sc), (div == 5'h00) ? 16'h0001 : 16'h0010);
      ew = w | hit(r, gt, lt, df);
      chk("enable", en, 1'b1);
      chk("done", done, 1'b1);
      chk("window", win, ew);
      arwd_cpu_model_i.rd(arwd_pkg::ADDR_RES_HI, b);
      chk("res_hi", b, r[15:8]);
      arwd_cpu_model_i.rd(arwd_pkg::ADDR_RES_LO, b);
      chk("res_lo", b, r[7:0]);
      arwd_cpu_model_i.rd(arwd_pkg::ADDR_CONTROL, b);
      chk("ctl_window", b[1], ew);
      chk("sar_idle", sclk, 1'b0);
      $display("test conversion %0d done", k);
    end
    close_out();
  end
endmodule // testbench
`default_nettype wire
